// *** src/wdt_defines.vh ***
/*
 Constants for the watchdog block: register offsets, field positions,
 reset values and timing. Assumes a 20 MHz core clock.
*/
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// Register byte offsets
`define WDT_OFS_COUNT      8'h00
`define WDT_OFS_CTRL       8'h04
`define WDT_OFS_HOLD_SET   8'h08
`define WDT_OFS_HOLD_CLR   8'h0C
`define WDT_OFS_STATUS     8'h10

// Count register fields
`define WDT_CNT_W          9
`define WDT_LOCK_BIT       9
`define WDT_SIGN_BIT       8
`define WDT_CNT_RESET      9'h0FF
`define WDT_CNT_ZERO       9'h000
`define WDT_CNT_ONE        9'h001
`define WDT_CNT_MINUS16    9'h1F0

// Control and hold fields
`define WDT_CTRL_DIRECT    0
`define WDT_HOLD_BIT       0

// Status fields
`define WDT_ST_HOLD        0
`define WDT_ST_DBG         1
`define WDT_ST_RST         2

// Tick period 10.24 ms in ns, core clock period in ns
`define WDT_TICK_NS        10240000
`define WDT_CLK_NS         50
`define WDT_TICK_CYC       (`WDT_TICK_NS / `WDT_CLK_NS)

// AHB encodings
`define WDT_HTRANS_NONSEQ  2'h2
`define WDT_HTRANS_SEQ     2'h3
`define WDT_HRESP_OKAY     1'h0

`endif

// *** src/wdt_tick_gen.v ***
/*
 Tick generator: one-cycle pulse every PERIOD core clocks.
 Assumes a single free running core clock.
*/
`timescale 1ns/1ns
`include "wdt_defines.vh"
module wdt_tick_gen #(
   parameter PERIOD = `WDT_TICK_CYC
) (
   // Clock and reset
   input  wire        i_core_clk,
   input  wire        i_resetn,
   // Tick out
   output reg         o_tick
);
   reg [31:0] div_r;

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         div_r  <= 32'h0000_0000;
         o_tick <= 1'b0;
      end else if (div_r == PERIOD - 1) begin
         div_r  <= 32'h0000_0000;
         o_tick <= 1'b1;
      end else begin
         div_r  <= div_r + 32'h0000_0001;
         o_tick <= 1'b0;
      end
   end
endmodule // wdt_tick_gen

// *** src/wdt_core.v ***
/*
 Watchdog timer with AHB-Lite register slave. 9-bit signed down counter,
 NMI pulse and sticky system reset request.
 Assumes i_resetn is driven by the system reset controller, which also
 receives o_sys_rst_req, so a watchdog reset returns this block to reset.
*/
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`include "wdt_defines.vh"

// How it works
// - Nine-bit signed count drops by one each tick unless held.
// - Count register resets to 255 for the longest time-out.
// - Count writes only take effect with write_lock_bit clear.
// - Below zero the sign bit sets; count runs 1, 0, 1FF down to 1F0.
// - Interrupt mode: NMI at zero, reset at minus sixteen or lower.
// - Direct mode: reset requested once count is zero or negative.
// - Watchdog reset is a system reset and restores count to 255.
// - Debug halt of the core freezes counting, not maskable.
// - Interrupt mode: hold-set bit freezes, hold-clear bit resumes.
// - Direct-reset bit is set-only by software, cleared by reset.
module wdt_core #(
   parameter TICK_CYCLES = `WDT_TICK_CYC
) (
   // Clock and reset
   input  wire        i_core_clk,
   input  wire        i_resetn,
   // AHB-Lite slave
   input  wire        i_hsel,
   input  wire [7:0]  i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [2:0]  i_hsize,
   input  wire [31:0] i_hwdata,
   input  wire        i_hready,
   output wire [31:0] o_hrdata,
   output wire        o_hreadyout,
   output wire        o_hresp,
   // Debug
   input  wire        i_debug_halt_ctrl_status,
   // Events
   output reg         o_nmi,
   output reg         o_sys_rst_req
);
   wire        tick;
   reg  [8:0]  cnt_r;
   reg  [8:0]  cnt_nxt;
   reg         direct_r;
   reg         hold_r;
   reg         wr_pend_r;
   reg  [7:0]  wr_addr_r;
   reg  [31:0] rdata_r;
   reg  [31:0] rdata_nxt;
   wire        addr_ok;
   wire        wr_count;
   wire        wr_ctrl;
   wire        wr_hset;
   wire        wr_hclr;
   wire        frozen;
   wire        do_dec;
   wire        direct_hit;
   wire        floor_hit;

   wdt_tick_gen #(
      .PERIOD (TICK_CYCLES)
   ) u_tick (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .o_tick     (tick)
   );

   // Zero wait states: always ready, always OKAY
   assign o_hreadyout = 1'b1;
   assign o_hresp     = `WDT_HRESP_OKAY;
   assign o_hrdata    = rdata_r;

   assign addr_ok = i_hsel && i_hready && i_htrans[1];

   always @* begin
      case (i_haddr)
         `WDT_OFS_COUNT:  rdata_nxt = {23'h000000, cnt_r};
         `WDT_OFS_CTRL:   rdata_nxt = {31'h00000000, direct_r};
         `WDT_OFS_HOLD_SET,
         `WDT_OFS_HOLD_CLR: rdata_nxt = {31'h00000000, hold_r};
         `WDT_OFS_STATUS: rdata_nxt = {29'h00000000, o_sys_rst_req,
                                       i_debug_halt_ctrl_status, hold_r};
         default:         rdata_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rdata_r   <= 32'h0000_0000;
      end else begin
         wr_pend_r <= addr_ok && i_hwrite;
         if (addr_ok) begin
            wr_addr_r <= i_haddr;
         end
         if (addr_ok && !i_hwrite) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign wr_count = wr_pend_r && (wr_addr_r == `WDT_OFS_COUNT) &&
                     !i_hwdata[`WDT_LOCK_BIT];
   assign wr_ctrl  = wr_pend_r && (wr_addr_r == `WDT_OFS_CTRL);
   assign wr_hset  = wr_pend_r && (wr_addr_r == `WDT_OFS_HOLD_SET) &&
                     i_hwdata[`WDT_HOLD_BIT];
   assign wr_hclr  = wr_pend_r && (wr_addr_r == `WDT_OFS_HOLD_CLR) &&
                     i_hwdata[`WDT_HOLD_BIT];

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         direct_r <= 1'b0;
      end else if (wr_ctrl && i_hwdata[`WDT_CTRL_DIRECT]) begin
         direct_r <= 1'b1;
      end
   end

   // software hold only in interrupt mode
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         hold_r <= 1'b0;
      end else if (!direct_r && wr_hset) begin
         hold_r <= 1'b1;
      end else if (!direct_r && wr_hclr) begin
         hold_r <= 1'b0;
      end
   end

   // debug freeze not maskable; hold ignored once direct mode set
   assign frozen = i_debug_halt_ctrl_status || (hold_r && !direct_r);
   // minus sixteen or lower
   // Written values below minus sixteen must not wrap back through zero
   assign floor_hit = cnt_r[`WDT_SIGN_BIT] && (cnt_r <= `WDT_CNT_MINUS16);
   // stop at minus sixteen, reset is already requested there
   assign do_dec = tick && !frozen && !floor_hit;

   always @* begin
      cnt_nxt = cnt_r;
      if (wr_count) begin
         cnt_nxt = i_hwdata[8:0];
      end else if (do_dec) begin
         cnt_nxt = cnt_r - `WDT_CNT_ONE;
      end
   end

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_r <= `WDT_CNT_RESET;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // zero or negative in direct mode
   assign direct_hit = direct_r && ((cnt_r == `WDT_CNT_ZERO) ||
                                    cnt_r[`WDT_SIGN_BIT]);

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_nmi         <= 1'b0;
         o_sys_rst_req <= 1'b0;
      end else begin
         // one NMI pulse on reaching zero
         o_nmi <= !direct_r && do_dec && !wr_count &&
                  (cnt_r == `WDT_CNT_ONE);
         if (direct_hit || (!direct_r && floor_hit)) begin
            o_sys_rst_req <= 1'b1;
         end
      end
   end
endmodule // wdt_core

// *** test/wdt_core_chk.sv ***
/* Checker for the watchdog: event outputs and register read-back.
   Assumes the top module's port names and one clock. */
`timescale 1ns/1ns
module wdt_core_chk (
   input wire        i_core_clk,
   input wire        i_resetn,
   input wire        i_hsel,
   input wire [7:0]  i_haddr,
   input wire [1:0]  i_htrans,
   input wire        i_hwrite,
   input wire [31:0] o_hrdata,
   input wire        i_debug_halt_ctrl_status,
   input wire        o_nmi,
   input wire        o_sys_rst_req);
   reg rd_cnt_r, rd_ctl_r, dir_r;
   wire rd_go = i_hsel & i_htrans[1] & ~i_hwrite;
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_cnt_r <= 1'b0;
         rd_ctl_r <= 1'b0;
         dir_r <= 1'b0;
      end else begin
         rd_cnt_r <= rd_go & (i_haddr == 8'h00);
         rd_ctl_r <= rd_go & (i_haddr == 8'h04);
         dir_r <= dir_r | (rd_ctl_r & o_hrdata[0]);
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   chk_nmi_pulse: assert property (o_nmi |=> (!o_nmi) [*7])
      else $error("nmi not a lone pulse");
   chk_rst_sticky: assert property (o_sys_rst_req |=> o_sys_rst_req)
      else $error("reset request dropped");
   chk_rst_clean: assert property ($rose(i_resetn) |-> !o_nmi && !o_sys_rst_req)
      else $error("events high after reset");
   chk_cnt_range: assert property (rd_cnt_r |-> o_hrdata[31:9] == 23'h0
      && (!o_hrdata[8] || o_hrdata[7:4] == 4'hF)) else $error("count out of range");
   chk_dbg_freeze: assert property (o_nmi |-> !$past(i_debug_halt_ctrl_status))
      else $error("nmi while halted");
   chk_rst_no_nmi: assert property ($rose(o_sys_rst_req) |-> !o_nmi)
      else $error("nmi with reset");
   chk_nmi_no_rst: assert property (o_nmi |-> !o_sys_rst_req)
      else $error("nmi after reset request");
   chk_ctrl_sticky: assert property (rd_ctl_r && dir_r |-> o_hrdata[0])
      else $error("direct bit cleared");
endmodule // wdt_core_chk
bind wdt_core wdt_core_chk u_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
   .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
   .o_hrdata(o_hrdata), .i_debug_halt_ctrl_status(i_debug_halt_ctrl_status),
   .o_nmi(o_nmi), .o_sys_rst_req(o_sys_rst_req));

// *** test/wdt_rst_model.sv ***
/* Reset controller model: power-on reset merged with the watchdog request.
   Assumes the request holds until reset lands. */
`timescale 1ns/1ns
module wdt_rst_model (
   input  wire i_core_clk,
   input  wire i_por_n,
   input  wire i_req,
   output wire o_resetn);
   reg [2:0] hold_r;
   always @(posedge i_core_clk or negedge i_por_n) begin
      if (!i_por_n) hold_r <= 3'h0;
      else if (i_req) hold_r <= 3'h4;
      else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
   end
   assign o_resetn = i_por_n & (hold_r == 3'h0);
endmodule // wdt_rst_model

// *** test/tb_top.sv ***
/* Watchdog bench: AHB-Lite master tasks, read monitor, bounded event waits.
   Assumes a short tick and the reset model in front. */
`timescale 1ns/1ns
`include "wdt_defines.vh"
module tb_top;
   reg clk = 0, por_n = 0, sel = 0, wr = 0, dbg = 0, rph = 0;
   reg [7:0] adr = 0;
   reg [1:0] trn = 0;
   reg [31:0] wd = 0, lf = 32'h8044;
   wire rdy, rsn, nmi, rq, rsp;
   wire [31:0] rd;
   integer n_mismatch = 0, checks_done = 0, i, j;
   reg [31:0] q[$];
   initial forever #25 clk = ~clk;
   wdt_rst_model rc (.i_core_clk(clk), .i_por_n(por_n), .i_req(rq), .o_resetn(rsn));
   wdt_core #(.TICK_CYCLES(8)) uut (.i_core_clk(clk), .i_resetn(rsn), .i_hsel(sel),
      .i_haddr(adr), .i_htrans(trn), .i_hwrite(wr), .i_hsize(3'h2), .i_hwdata(wd),
      .i_hready(rdy), .o_hrdata(rd), .o_hreadyout(rdy), .o_hresp(rsp),
      .i_debug_halt_ctrl_status(dbg), .o_nmi(nmi), .o_sys_rst_req(rq));
   function [31:0] nx(input [31:0] v);
      nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function sig(input [1:0] k);
      sig = k == 0 ? rdy : k == 1 ? nmi : k == 2 ? rq : rsn;
   endfunction
   task results;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_mismatch);
         if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task wfor(input [1:0] k, input v, input integer n);
      begin
         i = 0;
         while (sig(k) !== v && i < n) begin
            @(negedge clk);
            i = i + 1;
         end
         checks_done = checks_done + 1;
         if (sig(k) !== v) begin
            $display("unexpected wait %0d exp %b seen %b", k, v, sig(k));
            n_mismatch = n_mismatch + 1;
            results;
         end
      end
   endtask
   task xf(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         sel <= 1;
         adr <= a;
         wr <= w;
         trn <= `WDT_HTRANS_NONSEQ;
         if (!w) q.push_back(d);
         wfor(0, 1, 20);
         @(posedge clk);
         sel <= 0;
         trn <= 0;
         wd <= w ? d : 0;
         rph <= !w;
         wfor(0, 1, 20);
         @(posedge clk);
         rph <= 0;
      end
   endtask
   always @(posedge clk) begin
      if (rph && rdy && q.size() > 0) begin
         checks_done = checks_done + 1;
         if (rd !== q[0]) begin
            $display("unexpected hrdata exp %h seen %h", q[0], rd);
            n_mismatch = n_mismatch + 1;
         end
         void'(q.pop_front());
      end
      if (rph && rdy) begin
         checks_done = checks_done + 1;
         if (rsp !== `WDT_HRESP_OKAY) begin
            $display("unexpected hresp exp %b seen %b", `WDT_HRESP_OKAY, rsp);
            n_mismatch = n_mismatch + 1;
         end
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      por_n <= 1;
      xf(0, `WDT_OFS_COUNT, 32'h0FF);
      xf(1, `WDT_OFS_HOLD_SET, 32'h1);
      for (j = 0; j < 4; j = j + 1) begin
         lf = nx(lf);
         xf(1, `WDT_OFS_COUNT, lf | 32'h200);
      end
      xf(0, `WDT_OFS_COUNT, 32'h0FF);
      xf(1, `WDT_OFS_COUNT, 32'h2);
      xf(1, 8'h3C, 32'h5);
      xf(0, 8'h3C, 32'h0);
      xf(0, `WDT_OFS_STATUS, 32'h1);
      dbg <= 1;
      xf(1, `WDT_OFS_HOLD_CLR, 32'h1);
      xf(1, `WDT_OFS_COUNT, 32'h1FC);
      xf(0, `WDT_OFS_COUNT, 32'h1FC);
      xf(1, `WDT_OFS_COUNT, 32'h2);
      repeat (30) @(posedge clk);
      xf(0, `WDT_OFS_COUNT, 32'h2);
      dbg <= 0;
      wfor(1, 1, 40);
      xf(1, `WDT_OFS_COUNT, 32'h3);
      wfor(2, 1, 300);
      wfor(3, 0, 10);
      wfor(3, 1, 20);
      xf(0, `WDT_OFS_COUNT, 32'h0FF);
      for (j = 0; j < 2; j = j + 1) begin
         xf(1, `WDT_OFS_CTRL, {31'h0, j == 0});
         xf(0, `WDT_OFS_CTRL, 32'h1);
      end
      xf(1, `WDT_OFS_HOLD_SET, 32'h1);
      xf(0, `WDT_OFS_STATUS, 32'h0);
      xf(1, `WDT_OFS_COUNT, 32'h1);
      wfor(2, 1, 20);
      results;
   end
endmodule // tb_top
